// file: hdl/upio_top.sv
// User parallel port: main and auxiliary port, flag interrupt, handshake
`timescale 1ns/1ns
`default_nettype none
`include "upio_consts.svh"
module upio_top #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic [WIDTH-1:0] main_port_line_i,
  output logic [WIDTH-1:0] main_port_line_o,
  output logic [WIDTH-1:0] main_port_line_oe_o,
  input wire logic aux_port_line_two_i,
  output logic aux_port_line_two_o,
  output logic aux_port_line_two_oe_o,
  input wire logic falling_edge_flag_input_i,
  output logic handshake_output_n_o,
  output logic irq_n_o
);

  upio_pkg::upio_state_t st_reg;
  upio_pkg::upio_state_t st_next;
  upio_flag_if flag_if ();
  logic [7:0] aux_pins;
  logic [7:0] main_view;
  logic [7:0] aux_view;

  // Merge pin level with output latch: outputs read back what they drive
  function automatic logic [7:0] port_view(
    input logic [7:0] dir,
    input logic [7:0] dout,
    input logic [7:0] pins
  );
    port_view = (dir & dout) | (~dir & pins);
  endfunction

  // Address compare used by every register strobe
  function automatic logic hit(
    input logic [15:0] addr,
    input logic [15:0] target
  );
    hit = (addr == target);
  endfunction

  // Only line two of the auxiliary port reaches a pin; the other pin inputs are tied to zero
  always_comb begin
    aux_pins = 8'h00;
    aux_pins[`UPIO_AUX_LINE] = aux_port_line_two_i;
  end

  assign main_view = port_view(st_reg.main_dir, st_reg.main_data, main_port_line_i);
  assign aux_view = port_view(st_reg.aux_dir, st_reg.aux_data, aux_pins);
  assign flag_if.level = falling_edge_flag_input_i;

  upio_flag_edge u_edge (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .flag_if(flag_if)
  );

  // Next state: register writes, read mux, flag, interrupt and handshake
  always_comb begin
    st_next = st_reg;
    if (wr_en_i) begin
      if (hit(addr_i, `UPIO_ADDR_AUX_DATA)) begin
        st_next.aux_data = wdata_i;
      end
      if (hit(addr_i, `UPIO_ADDR_MAIN_DATA)) begin
        st_next.main_data = wdata_i;
      end
      if (hit(addr_i, `UPIO_ADDR_AUX_DIR)) begin
        st_next.aux_dir = wdata_i;
      end
      if (hit(addr_i, `UPIO_ADDR_MAIN_DIR)) begin
        st_next.main_dir = wdata_i;
      end
      if (hit(addr_i, `UPIO_ADDR_FLAG_CTRL)) begin
        st_next.flag_en = wdata_i[`UPIO_FLAG_EN_BIT];
      end
      // Write one clears the flag
      if (hit(addr_i, `UPIO_ADDR_FLAG_STAT) && wdata_i[`UPIO_FLAG_STAT_BIT]) begin
        st_next.flag = `UPIO_RST_BIT;
      end
    end
    // Edge after the clear so an event in the clear cycle is kept
    if (flag_if.fall) begin
      st_next.flag = 1'b1;
    end
    // Register read data; unmapped addresses answer zero
    if (rd_en_i) begin
      st_next.rdata = 8'h00;
      if (hit(addr_i, `UPIO_ADDR_AUX_DATA)) begin
        st_next.rdata = aux_view;
      end
      if (hit(addr_i, `UPIO_ADDR_MAIN_DATA)) begin
        st_next.rdata = main_view;
      end
      if (hit(addr_i, `UPIO_ADDR_AUX_DIR)) begin
        st_next.rdata = st_reg.aux_dir;
      end
      if (hit(addr_i, `UPIO_ADDR_MAIN_DIR)) begin
        st_next.rdata = st_reg.main_dir;
      end
      if (hit(addr_i, `UPIO_ADDR_FLAG_CTRL)) begin
        st_next.rdata[`UPIO_FLAG_EN_BIT] = st_reg.flag_en;
      end
      if (hit(addr_i, `UPIO_ADDR_FLAG_STAT)) begin
        st_next.rdata[`UPIO_FLAG_STAT_BIT] = st_reg.flag;
        st_next.rdata[`UPIO_IRQ_STAT_BIT] = ~st_reg.irq_n;
      end
    end
    // Request follows the registered flag and enable
    st_next.irq_n = ~(st_reg.flag & st_reg.flag_en);
    // Low for one cycle after any main port data access
    st_next.hs_n = ~((wr_en_i | rd_en_i) & hit(addr_i, `UPIO_ADDR_MAIN_DATA));
  end

  // Directions and flag clear on reset so no line drives before software sets it up
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg.aux_data <= `UPIO_RST_BYTE;
      st_reg.main_data <= `UPIO_RST_BYTE;
      st_reg.aux_dir <= `UPIO_RST_BYTE;
      st_reg.main_dir <= `UPIO_RST_BYTE;
      st_reg.flag_en <= `UPIO_RST_BIT;
      st_reg.flag <= `UPIO_RST_BIT;
      st_reg.irq_n <= `UPIO_RST_HIGH;
      st_reg.hs_n <= `UPIO_RST_HIGH;
      st_reg.rdata <= `UPIO_RST_BYTE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flip-flops
  assign rdata_o = st_reg.rdata;
  assign main_port_line_o = st_reg.main_data;
  assign main_port_line_oe_o = st_reg.main_dir;
  assign aux_port_line_two_o = st_reg.aux_data[`UPIO_AUX_LINE];
  assign aux_port_line_two_oe_o = st_reg.aux_dir[`UPIO_AUX_LINE];
  assign handshake_output_n_o = st_reg.hs_n;
  assign irq_n_o = st_reg.irq_n;

  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  // Decoded strobes shared by the checks
  logic main_dir_wr;
  logic main_data_wr;
  logic main_data_rd;
  logic aux_dir_wr;
  logic aux_data_wr;
  logic stat_clr;
  assign main_dir_wr = wr_en_i & hit(addr_i, `UPIO_ADDR_MAIN_DIR);
  assign main_data_wr = wr_en_i & hit(addr_i, `UPIO_ADDR_MAIN_DATA);
  assign main_data_rd = rd_en_i & hit(addr_i, `UPIO_ADDR_MAIN_DATA);
  assign aux_dir_wr = wr_en_i & hit(addr_i, `UPIO_ADDR_AUX_DIR);
  assign aux_data_wr = wr_en_i & hit(addr_i, `UPIO_ADDR_AUX_DATA);
  assign stat_clr = wr_en_i & hit(addr_i, `UPIO_ADDR_FLAG_STAT) & wdata_i[`UPIO_FLAG_STAT_BIT];

  a_main_oe_follow: assert property (main_dir_wr |=>
    main_port_line_oe_o == $past(wdata_i))
    else $error("main enable does not follow direction write");
  // Enables move only on a direction write, so lines never disturb each other
  a_dir_per_line: assert property (!main_dir_wr |=> $stable(main_port_line_oe_o))
    else $error("direction bits change without a write");
  a_main_out_drive: assert property (main_data_wr |=>
    main_port_line_o == $past(wdata_i))
    else $error("main output does not follow data write");
  // Expected view built from the pins: drive value on outputs, pin level on inputs
  a_main_read_view: assert property (main_data_rd |=>
    rdata_o == $past((main_port_line_oe_o & main_port_line_o) |
    (~main_port_line_oe_o & main_port_line_i)))
    else $error("main read does not return pin view");
  a_dir_readback: assert property (main_dir_wr ##1
    (rd_en_i && addr_i == `UPIO_ADDR_MAIN_DIR) |=> rdata_o == $past(wdata_i, 2))
    else $error("direction read back wrong");
  // Flag and interrupt; a clear and an edge in one cycle keep the flag
  a_flag_on_fall: assert property ($fell(falling_edge_flag_input_i) |=> st_reg.flag)
    else $error("flag not set by falling edge");
  a_flag_quiet: assert property (!st_reg.flag && !flag_if.fall |=> !st_reg.flag)
    else $error("flag set without falling edge");
  a_irq_raise: assert property (st_reg.flag && st_reg.flag_en |=> !irq_n_o)
    else $error("interrupt missing with flag enabled");
  a_irq_clear: assert property (!st_reg.flag |=> irq_n_o)
    else $error("interrupt raised with flag clear");
  a_irq_masked: assert property (!st_reg.flag_en |=> irq_n_o)
    else $error("interrupt raised while disabled");
  a_flag_held: assert property (st_reg.flag && !stat_clr |=> st_reg.flag)
    else $error("flag lost without a clear");
  // Auxiliary line two follows its own data and direction bits
  a_aux_oe_follow: assert property (aux_dir_wr |=>
    aux_port_line_two_oe_o == $past(wdata_i[`UPIO_AUX_LINE]))
    else $error("auxiliary enable does not follow direction");
  a_aux_out_drive: assert property (aux_data_wr |=>
    aux_port_line_two_o == $past(wdata_i[`UPIO_AUX_LINE]))
    else $error("auxiliary output does not follow data write");
  // Handshake pulses only after a main port data access
  a_hs_pulse: assert property (main_data_wr || main_data_rd |=> !handshake_output_n_o)
    else $error("handshake pulse missing");
  a_hs_idle: assert property (!(main_data_wr || main_data_rd) |=> handshake_output_n_o)
    else $error("handshake low without access");
  a_reset_state: assert property ($rose(resetn_i) |->
    main_port_line_oe_o == `UPIO_RST_BYTE && !aux_port_line_two_oe_o && !st_reg.flag)
    else $error("state not cleared by reset");
  a_set_wins: assert property (stat_clr && flag_if.fall |=> st_reg.flag)
    else $error("flag lost during clear");

  // Main scenarios the bench is expected to reach
  c_flag_irq: cover property ($fell(falling_edge_flag_input_i) ##2 !irq_n_o);
  c_main_write_drive: cover property (main_dir_wr ##1 main_data_wr);
  c_flag_clear: cover property (st_reg.flag ##1 stat_clr ##1 !st_reg.flag);
  c_main_read: cover property (main_data_rd ##1 !handshake_output_n_o);
  c_set_wins: cover property (stat_clr && flag_if.fall);

endmodule
`default_nettype wire

// file: hdl/upio_consts.svh
// Address map, field positions and reset values of the user parallel port
//
// Overview of operation
// - Direction bit one drives the main port line; zero leaves it an input.
// - Each of the eight main lines has its own direction bit.
// - Main port data at 56577 reads input levels and drives outputs.
// - Main port direction register sits at 56579, read and write.
// - A falling edge on the flag input sets the flag bit.
// - Interrupt request asserts while the flag bit is set and enabled.
// - With the flag interrupt disabled the bit is still readable, no request.
// - Auxiliary line two behaves as a port bit; data 56576, direction 56578.
// - Two handshake lines: falling-edge flag input and handshake output.
`ifndef UPIO_CONSTS_SVH
`define UPIO_CONSTS_SVH

`define UPIO_ADDR_AUX_DATA 16'hDD00
`define UPIO_ADDR_MAIN_DATA 16'hDD01
`define UPIO_ADDR_AUX_DIR 16'hDD02
`define UPIO_ADDR_MAIN_DIR 16'hDD03
`define UPIO_ADDR_FLAG_CTRL 16'hDD04
`define UPIO_ADDR_FLAG_STAT 16'hDD05

`define UPIO_AUX_LINE 2
`define UPIO_FLAG_EN_BIT 0
`define UPIO_FLAG_STAT_BIT 0
`define UPIO_IRQ_STAT_BIT 7

`define UPIO_RST_BYTE 8'h00
`define UPIO_RST_BIT 1'b0
`define UPIO_RST_HIGH 1'b1

`endif

// file: hdl/upio_pkg.sv
// Types shared by the user parallel port modules
package upio_pkg;

  // Whole state of the port top module
  typedef struct packed {
    logic [7:0] aux_data;
    logic [7:0] main_data;
    logic [7:0] aux_dir;
    logic [7:0] main_dir;
    logic flag_en;
    logic flag;
    logic irq_n;
    logic hs_n;
    logic [7:0] rdata;
  } upio_state_t;

  // State of the flag edge detector
  typedef struct packed {
    logic prev;
  } upio_edge_state_t;

endpackage

// file: hdl/upio_flag_if.sv
// Carrier between the flag edge detector and the port core
`timescale 1ns/1ns
`default_nettype none
interface upio_flag_if;
  logic level;
  logic fall;

  modport detector (
    input level,
    output fall
  );

  modport core (
    output level,
    input fall
  );
endinterface
`default_nettype wire

// file: hdl/upio_flag_edge.sv
// Falling-edge detector for the flag input line
`timescale 1ns/1ns
`default_nettype none
`include "upio_consts.svh"
module upio_flag_edge (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  upio_flag_if.detector flag_if
);

  upio_pkg::upio_edge_state_t st_reg;
  upio_pkg::upio_edge_state_t st_next;

  // Idle line is high, so reset to high avoids a false edge
  always_comb begin
    st_next = st_reg;
    st_next.prev = flag_if.level;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg.prev <= `UPIO_RST_HIGH;
    end else begin
      st_reg <= st_next;
    end
  end

  // One-cycle pulse on high-to-low transition
  assign flag_if.fall = st_reg.prev & ~flag_if.level;

endmodule
`default_nettype wire

// file: tb/upio_periph.sv
// Peripheral model standing on the far side of the user port
`timescale 1ns/1ns
`default_nettype none
module upio_periph (
  input wire logic [7:0] dut_line_i,
  input wire logic [7:0] dut_oe_i,
  input wire logic [7:0] drive_i,
  input wire logic dut_aux_i,
  input wire logic dut_aux_oe_i,
  input wire logic flag_lvl_i,
  output logic [7:0] line_o,
  output logic aux_o,
  output logic flag_o
);
  // Wire level: device wins on driven lines, peripheral drives the rest
  assign line_o = (dut_oe_i & dut_line_i) | (~dut_oe_i & drive_i);
  assign aux_o = dut_aux_oe_i ? dut_aux_i : drive_i[2];
  // Flag line follows the peripheral's handshake level
  assign flag_o = flag_lvl_i;
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking testbench of the user parallel port
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin \
  n_tests++; \
  if ((got) !== (ex)) begin \
    fails++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); \
  end \
end
module tb;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, line_o, oe, line_i, drive, rd;
  logic aux_i, aux_o, aux_oe, flag_pin, hs_n, irq_n, hs_last;
  logic flag_lvl = 1'b1;
  int n_tests = 0;
  int fails = 0;

  upio_top #(.WIDTH(8)) DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .wdata_i(wdata), .rdata_o(rdata),
    .main_port_line_i(line_i), .main_port_line_o(line_o), .main_port_line_oe_o(oe),
    .aux_port_line_two_i(aux_i), .aux_port_line_two_o(aux_o),
    .aux_port_line_two_oe_o(aux_oe), .falling_edge_flag_input_i(flag_pin),
    .handshake_output_n_o(hs_n), .irq_n_o(irq_n));
  upio_periph periph (.dut_line_i(line_o), .dut_oe_i(oe), .drive_i(drive),
    .dut_aux_i(aux_o), .dut_aux_oe_i(aux_oe), .flag_lvl_i(flag_lvl),
    .line_o(line_i), .aux_o(aux_i), .flag_o(flag_pin));

  // 100 MHz system clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // One-cycle strobes; handshake level sampled after the taking edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk_sys_i);
    #1;
    wr_en = 1'b0;
    hs_last = hs_n;
  endtask
  task automatic rdr(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    addr = a;
    rd_en = 1'b1;
    @(posedge clk_sys_i);
    #1;
    rd_en = 1'b0;
    d = rdata;
    hs_last = hs_n;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Reset values at the pins and in both direction registers
  task automatic t_reset();
    `CHK("oe", 8'h00, oe)
    `CHK("aux_oe", 1'b0, aux_oe)
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("hs_rst", 1'b1, hs_n)
    rdr(16'hDD03, rd);
    `CHK("main_dir", 8'h00, rd)
    rdr(16'hDD02, rd);
    `CHK("aux_dir", 8'h00, rd)
    rdr(16'hDD05, rd);
    `CHK("flag_stat", 8'h00, rd)
    $display("test reset done");
  endtask

  // Mixed directions, per-line independence and handshake pulse
  task automatic t_main();
    drive = 8'h5A;
    for (int i = 0; i < 8; i++) begin
      wr(16'hDD03, 8'h01 << i);
      `CHK("oe_one", 8'h01 << i, oe)
    end
    wr(16'hDD03, 8'h38);
    wr(16'hDD01, 8'hA5);
    `CHK("hs_wr", 1'b0, hs_last)
    cyc(1);
    `CHK("hs_idle", 1'b1, hs_n)
    `CHK("oe", 8'h38, oe)
    `CHK("line_o", 8'hA5, line_o)
    rdr(16'hDD01, rd);
    `CHK("pins", (8'h38 & 8'hA5) | (~8'h38 & 8'h5A), rd)
    `CHK("hs_rd", 1'b0, hs_last)
    rdr(16'hDD03, rd);
    `CHK("dir_rd", 8'h38, rd)
    $display("test main port done");
  endtask

  // Auxiliary line two as input, then as output
  task automatic t_aux();
    drive = 8'h04;
    rdr(16'hDD00, rd);
    `CHK("aux_in", 8'h04, rd)
    wr(16'hDD02, 8'h04);
    wr(16'hDD00, 8'h00);
    `CHK("hs_aux", 1'b1, hs_last)
    `CHK("aux_oe", 1'b1, aux_oe)
    `CHK("aux_o", 1'b0, aux_o)
    rdr(16'hDD00, rd);
    `CHK("aux_out", 8'h00, rd)
    rdr(16'hDD02, rd);
    `CHK("aux_dir", 8'h04, rd)
    $display("test aux port done");
  endtask

  // Flag polled while disabled, then enabled, cleared, and set during a clear
  task automatic t_flag();
    wr(16'hDD04, 8'h00);
    flag_lvl = 1'b0;
    cyc(3);
    `CHK("irq_off", 1'b1, irq_n)
    rdr(16'hDD05, rd);
    `CHK("flag_poll", 8'h01, rd)
    wr(16'hDD04, 8'h01);
    cyc(2);
    `CHK("irq_on", 1'b0, irq_n)
    rdr(16'hDD05, rd);
    `CHK("flag_irq", 8'h81, rd)
    wr(16'hDD05, 8'h01);
    cyc(2);
    `CHK("irq_clr", 1'b1, irq_n)
    flag_lvl = 1'b1;
    rdr(16'hDD07, rd);
    `CHK("unmapped", 8'h00, rd)
    // Clear write and falling edge taken at the same edge: the set must win
    @(posedge clk_sys_i);
    #1;
    addr = 16'hDD05;
    wdata = 8'h01;
    wr_en = 1'b1;
    flag_lvl = 1'b0;
    @(posedge clk_sys_i);
    #1;
    wr_en = 1'b0;
    rdr(16'hDD05, rd);
    `CHK("set_wins", 8'h81, rd)
    rdr(16'hDD04, rd);
    `CHK("flag_en", 8'h01, rd)
    flag_lvl = 1'b1;
    $display("test flag done");
  endtask

  // Reset in mid-run while lines drive and the flag is set
  task automatic t_mid_reset();
    @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b0;
    cyc(2);
    resetn_i = 1'b1;
    t_reset();
  endtask

  // Hang guard
  initial begin
    #100000;
    fails++;
    close_out();
  end

  // Main sequence
  initial begin
    drive = 8'h00;
    repeat (2) @(posedge clk_sys_i);
    #1 resetn_i = 1'b1;
    t_reset();
    t_main();
    t_aux();
    t_flag();
    t_mid_reset();
    close_out();
  end
endmodule
`default_nettype wire
